// ==== rtl/ipc_regs.svh ====
/*
 Register offsets, field codes and reset values of the isolated
 port configuration space. Assumes byte addresses as printed.
*/
`ifndef IPC_REGS_SVH
`define IPC_REGS_SVH
`define IPC_OFF_BAR3     8'h1C
`define IPC_OFF_BAR4     8'h20
`define IPC_OFF_BAR5     8'h24
`define IPC_OFF_SUBSYS   8'h2C
`define IPC_OFF_CAPPTR   8'h34
`define IPC_OFF_INTR     8'h3C
`define IPC_OFF_PMCAP    8'h40
`define IPC_OFF_PMCSR    8'h44
`define IPC_OFF_MSICAP   8'h48
`define IPC_OFF_MSIADDR  8'h4C
`define IPC_OFF_MSIUADDR 8'h50
`define IPC_OFF_MSIDATA  8'h54
`define IPC_OFF_EXPCAP   8'h68
`define IPC_OFF_DEVCAP   8'h6C
`define IPC_OFF_DEVCTL   8'h70
`define IPC_TYPE_64      2'h2
`define IPC_D0           2'h0
`define IPC_D3HOT        2'h3
`define IPC_PM_ID        8'h01
`define IPC_PM_REV       3'h3
`define IPC_MSI_ID       8'h05
`define IPC_EXP_ID       8'h10
`define IPC_EXP_VER      4'h2
`define IPC_EXP_TYPE     4'h0
`define IPC_L0S_LAT      3'h7
`define IPC_L1_LAT       3'h7
`define IPC_MSI_64       1'h1
`define IPC_DEF_SUBSYSTEM_VENDOR_CODE    16'h1234
`define IPC_DEF_SUBSYSTEM_DEVICE_CODE     16'h5678
`define IPC_DEF_CAPPTR   8'h40
`define IPC_DEF_INTPIN   8'h01
`define IPC_DEF_PMNEXT   8'h48
`define IPC_DEF_PMSUP    5'h19
`define IPC_DEF_NSR      1'h1
`define IPC_DEF_MSINEXT  8'h68
`define IPC_DEF_EXPNEXT  8'hA4
`define IPC_DEF_MPSSUP   3'h1
`define IPC_DEF_RBER     1'h1
`endif

// ==== rtl/ipc_pkg.sv ====
/*
 Types shared by the isolated port configuration space.
 Assumes the offsets and values of ipc_regs.svh.
*/
package ipc_pkg;
   typedef logic [31:0] ipc_word_t;
   typedef enum logic [1:0] {
      IPC_PS_D0  = 2'h0,
      IPC_PS_D1  = 2'h1,
      IPC_PS_D2  = 2'h2,
      IPC_PS_D3H = 2'h3
   } ipc_pstate_t;
endpackage

// ==== rtl/ipc_rst_sync.sv ====
/*
 Reset release synchroniser: asynchronous assert, two-flop release.
 Assumes rst_n may change at any time relative to sys_clk.
*/
`timescale 1ns/1ps
module ipc_rst_sync import ipc_pkg::*; (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   output logic      rst_sync_n
);
   logic stage;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage      <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         stage      <= 1'b1;
         rst_sync_n <= stage;
      end
   end
endmodule // ipc_rst_sync

// ==== rtl/ipc_loader.sv ====
/*
 Shadow of the loadable identification and capability defaults.
 Assumes the serial loader presents one word per ld_valid, same clock.
*/
`timescale 1ns/1ps
`include "ipc_regs.svh"
module ipc_loader import ipc_pkg::*; (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       ld_valid,
   input  wire logic [7:0] ld_addr,
   input  wire ipc_word_t  ld_data,
   output logic [15:0]     subsystem_vendor_code,
   output logic [15:0]     subsystem_device_code,
   output logic [7:0]      cap_ptr,
   output logic [7:0]      int_pin,
   output logic [7:0]      pm_next,
   output logic [10:0]     pm_caps,
   output logic            no_soft_rst,
   output logic [7:0]      power_mgmt_control_status,
   output logic [7:0]      msi_next,
   output logic [7:0]      exp_next,
   output logic [2:0]      mps_sup,
   output logic            rber,
   output logic [1:0]      bar4_type
);
   // Loadable defaults, D1/D2 support stays zero from reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         subsystem_vendor_code       <= `IPC_DEF_SUBSYSTEM_VENDOR_CODE;
         subsystem_device_code        <= `IPC_DEF_SUBSYSTEM_DEVICE_CODE;
         cap_ptr     <= `IPC_DEF_CAPPTR;
         int_pin     <= `IPC_DEF_INTPIN;
         pm_next     <= `IPC_DEF_PMNEXT;
         pm_caps     <= {`IPC_DEF_PMSUP, 6'h00};
         no_soft_rst <= `IPC_DEF_NSR;
         power_mgmt_control_status     <= 8'h00;
         msi_next    <= `IPC_DEF_MSINEXT;
         exp_next    <= `IPC_DEF_EXPNEXT;
         mps_sup     <= `IPC_DEF_MPSSUP;
         rber        <= `IPC_DEF_RBER;
         bar4_type   <= 2'h0;
      end else if (ld_valid) begin
         case (ld_addr)
            `IPC_OFF_BAR4: bar4_type <= ld_data[2:1];
            `IPC_OFF_SUBSYS: begin
               subsystem_vendor_code <= ld_data[15:0];
               subsystem_device_code  <= ld_data[31:16];
            end
            `IPC_OFF_CAPPTR: cap_ptr <= ld_data[7:0];
            `IPC_OFF_INTR: int_pin <= {7'h00, ld_data[8]};
            `IPC_OFF_PMCAP: begin
               pm_next <= ld_data[15:8];
               pm_caps <= ld_data[31:21];
            end
            `IPC_OFF_PMCSR: begin
               no_soft_rst <= ld_data[3];
               power_mgmt_control_status     <= ld_data[31:24];
            end
            `IPC_OFF_MSICAP: msi_next <= ld_data[15:8];
            `IPC_OFF_EXPCAP: exp_next <= ld_data[15:8];
            `IPC_OFF_DEVCAP: begin
               mps_sup <= ld_data[2:0];
               rber    <= ld_data[15];
            end
            default: ;
         endcase
      end
   end
endmodule // ipc_loader

// ==== rtl/ipc_config_space.sv ====
/*
 Isolated port type 0 configuration space, offsets 1Ch to 70h, as an
 APB slave. Assumes all side inputs come from logic on sys_clk.
*/
`timescale 1ns/1ps
`include "ipc_regs.svh"
module ipc_config_space import ipc_pkg::*; (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pwrite,
   input  wire logic [7:0] paddr,
   input  wire ipc_word_t  pwdata,
   input  wire logic [3:0] pstrb,
   output ipc_word_t       prdata,
   output logic            pready,
   output logic            pslverr,
   input  wire logic [1:0] bar2_type,
   input  wire logic       data_sel_wr_en,
   input  wire logic       pme_req,
   input  wire logic       spl_valid,
   input  wire logic [7:0] spl_value,
   input  wire logic [1:0] spl_scale,
   input  wire logic       ld_valid,
   input  wire logic [7:0] ld_addr,
   input  wire ipc_word_t  ld_data,
   output logic            downstream_reset_out_n,
   output logic            hot_reset_pulse,
   output logic            internal_reset_pulse,
   output logic            pme_msg,
   output logic            msi_en,
   output logic            intx_allowed,
   output logic [2:0]      msi_mme,
   output logic [63:0]     msi_addr,
   output logic [15:0]     msi_data,
   output logic [3:0]      err_report_en,
   output logic [2:0]      max_payload,
   output logic [1:0]      power_state
);
   logic        rst_s_n;
   logic [15:0] subsystem_vendor_code;
   logic [15:0] subsystem_device_code;
   logic [7:0]  cap_ptr;
   logic [7:0]  int_pin;
   logic [7:0]  pm_next;
   logic [10:0] pm_caps;
   logic        no_soft_rst;
   logic [7:0]  power_mgmt_control_status;
   logic [7:0]  msi_next;
   logic [7:0]  exp_next;
   logic [2:0]  mps_sup;
   logic        rber;
   logic [1:0]  bar4_type;
   ipc_word_t   bar3;
   logic [11:0] bar4_base;
   ipc_word_t   bar5;
   logic [7:0]  int_line;
   logic        pme_en;
   logic [3:0]  data_sel;
   logic [29:0] msi_alo;
   ipc_word_t   msi_ahi;
   logic [7:0]  spl_val_q;
   logic [1:0]  spl_scale_q;
   ipc_word_t   rd_word;
   logic        hit;
   logic        wr;
   ipc_word_t   wm;
   logic        soft_rst;
   logic        bar23_64;
   logic        bar45_64;
   logic [2:0]  next_mps;

   ipc_rst_sync u_rst (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .rst_sync_n (rst_s_n)
   );

   ipc_loader u_ld (
      .sys_clk     (sys_clk),
      .rst_n       (rst_s_n),
      .ld_valid    (ld_valid),
      .ld_addr     (ld_addr),
      .ld_data     (ld_data),
      .subsystem_vendor_code       (subsystem_vendor_code),
      .subsystem_device_code        (subsystem_device_code),
      .cap_ptr     (cap_ptr),
      .int_pin     (int_pin),
      .pm_next     (pm_next),
      .pm_caps     (pm_caps),
      .no_soft_rst (no_soft_rst),
      .power_mgmt_control_status     (power_mgmt_control_status),
      .msi_next    (msi_next),
      .exp_next    (exp_next),
      .mps_sup     (mps_sup),
      .rber        (rber),
      .bar4_type   (bar4_type)
   );

   // Byte-lane merge of a write onto the current contents
   function automatic ipc_word_t ipc_merge(input ipc_word_t o,
                                           input ipc_word_t w,
                                           input logic [3:0] s);
      ipc_word_t r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Zero-wait slave: read data is captured in the setup cycle
   assign pready   = 1'b1;
   assign wr       = psel && penable && pwrite && hit;
   assign bar23_64 = (bar2_type == `IPC_TYPE_64);
   assign bar45_64 = (bar4_type == `IPC_TYPE_64);
   assign soft_rst = internal_reset_pulse;
   assign pslverr  = psel && penable && !hit;
   assign intx_allowed = !msi_en;
   assign msi_addr = {msi_ahi, msi_alo, 2'h0};

   always_comb begin
      wm       = '0;
      next_mps = '0;
      case (paddr)
         `IPC_OFF_BAR3:     wm = bar3;
         `IPC_OFF_BAR4:     wm = {bar4_base, 20'h0};
         `IPC_OFF_BAR5:     wm = bar5;
         `IPC_OFF_INTR:     wm = {24'h0, int_line};
         `IPC_OFF_PMCSR:    wm = {19'h0, data_sel, pme_en, 6'h0, power_state};
         `IPC_OFF_MSICAP:   wm = {8'h0, 1'b0, msi_mme, 3'h0, msi_en, 16'h0};
         `IPC_OFF_MSIADDR:  wm = {msi_alo, 2'h0};
         `IPC_OFF_MSIUADDR: wm = msi_ahi;
         `IPC_OFF_MSIDATA:  wm = {16'h0, msi_data};
         `IPC_OFF_DEVCTL:   wm = {24'h0, max_payload, 1'b0, err_report_en};
         default:           wm = '0;
      endcase
      wm = ipc_merge(wm, pwdata, pstrb);
      next_mps = (wm[7:5] > mps_sup) ? mps_sup : wm[7:5];
   end

   // Read mux; unused and reserved bits read zero
   always_comb begin
      hit     = 1'b1;
      rd_word = '0;
      case (paddr)
         `IPC_OFF_BAR3:    rd_word = bar3;
         `IPC_OFF_BAR4:    rd_word = {bar4_base, 16'h0, 1'b0,
                                      bar4_type, 1'b0};
         `IPC_OFF_BAR5:    rd_word = bar5;
         `IPC_OFF_SUBSYS:  rd_word = {subsystem_device_code, subsystem_vendor_code};
         `IPC_OFF_CAPPTR:  rd_word = {24'h0, cap_ptr};
         `IPC_OFF_INTR:    rd_word = {16'h0, int_pin, int_line};
         `IPC_OFF_PMCAP:   rd_word = {pm_caps[10:6], 2'h0, pm_caps[3:0],
                                      2'h0, `IPC_PM_REV,
                                      pm_next, `IPC_PM_ID};
         `IPC_OFF_PMCSR:   rd_word = {power_mgmt_control_status, 2'h0, 6'h0, 1'b0, 2'h0,
                                      data_sel, pme_en, 4'h0,
                                      no_soft_rst, 1'b0,
                                      power_state};
         `IPC_OFF_MSICAP:  rd_word = {8'h0, `IPC_MSI_64, msi_mme, 3'h0,
                                      msi_en, msi_next, `IPC_MSI_ID};
         `IPC_OFF_MSIADDR: rd_word = {msi_alo, 2'h0};
         `IPC_OFF_MSIUADDR: rd_word = msi_ahi;
         `IPC_OFF_MSIDATA: rd_word = {16'h0, msi_data};
         `IPC_OFF_EXPCAP:  rd_word = {8'h0, `IPC_EXP_TYPE, `IPC_EXP_VER,
                                      exp_next, `IPC_EXP_ID};
         `IPC_OFF_DEVCAP:  rd_word = {4'h0, spl_scale_q, spl_val_q, 2'h0,
                                      rber, 3'h0, `IPC_L1_LAT,
                                      `IPC_L0S_LAT, 3'h0,
                                      mps_sup};
         `IPC_OFF_DEVCTL:  rd_word = {24'h0, max_payload, 1'b0,
                                      err_report_en};
         default:          hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_word;
      end
   end

   // Upper halves only take writes in 64-bit mode
   always_ff @(posedge sys_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         bar3      <= '0;
         bar4_base <= '0;
         bar5      <= '0;
      end else if (soft_rst) begin
         bar3      <= '0;
         bar4_base <= '0;
         bar5      <= '0;
      end else begin
         if (!bar23_64) begin
            bar3 <= '0;
         end else if (wr && paddr == `IPC_OFF_BAR3) begin
            bar3 <= wm;
         end
         if (wr && paddr == `IPC_OFF_BAR4) begin
            bar4_base <= wm[31:20];
         end
         if (!bar45_64) begin
            bar5 <= '0;
         end else if (wr && paddr == `IPC_OFF_BAR5) begin
            bar5 <= wm;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         int_line <= '0;
      end else if (soft_rst) begin
         int_line <= '0;
      end else if (wr && paddr == `IPC_OFF_INTR) begin
         int_line <= wm[7:0];
      end
   end

   // Power state; a D3hot to D0 write is the hot reset event
   always_ff @(posedge sys_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         power_state          <= `IPC_D0;
         pme_en               <= 1'b0;
         data_sel             <= '0;
         hot_reset_pulse      <= 1'b0;
         internal_reset_pulse <= 1'b0;
      end else begin
         hot_reset_pulse      <= 1'b0;
         internal_reset_pulse <= 1'b0;
         if (wr && paddr == `IPC_OFF_PMCSR) begin
            power_state <= wm[1:0];
            if (pstrb[1]) begin
               pme_en <= wm[8];
            end
            if (data_sel_wr_en) begin
               data_sel <= wm[12:9];
            end
            if (power_state == `IPC_D3HOT && wm[1:0] == `IPC_D0) begin
               hot_reset_pulse      <= 1'b1;
               internal_reset_pulse <= !no_soft_rst;
            end
         end
      end
   end

   // The downstream reset stays released through a hot reset
   always_ff @(posedge sys_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         downstream_reset_out_n <= 1'b1;
         pme_msg                <= 1'b0;
      end else begin
         downstream_reset_out_n <= 1'b1;
         pme_msg                <= pme_req && pme_en;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         msi_en   <= 1'b0;
         msi_mme  <= '0;
         msi_alo  <= '0;
         msi_ahi  <= '0;
         msi_data <= '0;
      end else if (soft_rst) begin
         msi_en   <= 1'b0;
         msi_mme  <= '0;
         msi_alo  <= '0;
         msi_ahi  <= '0;
         msi_data <= '0;
      end else if (wr) begin
         case (paddr)
            `IPC_OFF_MSICAP: begin
               msi_en  <= wm[16];
               msi_mme <= wm[22:20];
            end
            `IPC_OFF_MSIADDR:  msi_alo  <= wm[31:2];
            `IPC_OFF_MSIUADDR: msi_ahi  <= wm;
            `IPC_OFF_MSIDATA:  msi_data <= wm[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         err_report_en <= '0;
         max_payload   <= '0;
      end else if (soft_rst) begin
         err_report_en <= '0;
         max_payload   <= '0;
      end else if (wr && paddr == `IPC_OFF_DEVCTL) begin
         err_report_en <= wm[3:0];
         max_payload   <= next_mps;
      end
   end

   // Slot power limit is only ever set by the message
   always_ff @(posedge sys_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         spl_val_q   <= '0;
         spl_scale_q <= '0;
      end else if (spl_valid) begin
         spl_val_q   <= spl_value;
         spl_scale_q <= spl_scale;
      end
   end

   property p_bar3_fixed;
      @(posedge sys_clk) disable iff (!rst_s_n)
      !bar23_64 |=> bar3 == '0;
   endproperty
   a_bar3_fixed: assert property (p_bar3_fixed) else $error("bar3 writable in 32-bit");

   property p_bar4_rsvd;
      @(posedge sys_clk) disable iff (!rst_s_n)
      psel && penable && !pwrite && paddr == `IPC_OFF_BAR4 |-> prdata[19:3] == '0;
   endproperty
   a_bar4_rsvd: assert property (p_bar4_rsvd) else $error("bar4 low bits nonzero");

   property p_capptr;
      @(posedge sys_clk) disable iff (!rst_s_n)
      psel && penable && !pwrite && paddr == `IPC_OFF_CAPPTR && !$past(ld_valid, 2)
      |-> prdata == {24'h0, cap_ptr};
   endproperty
   a_capptr: assert property (p_capptr) else $error("capability pointer wrong");

   property p_hot_reset;
      @(posedge sys_clk) disable iff (!rst_s_n)
      wr && paddr == `IPC_OFF_PMCSR && power_state == `IPC_D3HOT && wm[1:0] == `IPC_D0
      |=> hot_reset_pulse && downstream_reset_out_n ##1 !hot_reset_pulse;
   endproperty
   a_hot_reset: assert property (p_hot_reset) else $error("hot reset missing");

   property p_soft;
      @(posedge sys_clk) disable iff (!rst_s_n)
      internal_reset_pulse |-> hot_reset_pulse && !$past(no_soft_rst);
   endproperty
   a_soft: assert property (p_soft) else $error("internal reset unexpected");

   property p_pme;
      @(posedge sys_clk) disable iff (!rst_s_n)
      pme_req && !pme_en |=> !pme_msg;
   endproperty
   a_pme: assert property (p_pme) else $error("pme sent while disabled");

   property p_dsel;
      @(posedge sys_clk) disable iff (!rst_s_n)
      !data_sel_wr_en && !soft_rst |=> $stable(data_sel);
   endproperty
   a_dsel: assert property (p_dsel) else $error("data select changed while locked");

   property p_intx;
      @(posedge sys_clk) disable iff (!rst_s_n)
      msi_en |-> !intx_allowed;
   endproperty
   a_intx: assert property (p_intx) else $error("intx with msi enabled");

   property p_spl;
      @(posedge sys_clk) disable iff (!rst_s_n)
      spl_valid |=> spl_val_q == $past(spl_value) && spl_scale_q == $past(spl_scale);
   endproperty
   a_spl: assert property (p_spl) else $error("slot power not captured");

   property p_mps;
      @(posedge sys_clk) disable iff (!rst_s_n)
      wr && paddr == `IPC_OFF_DEVCTL && wm[7:5] > mps_sup |=> max_payload == $past(mps_sup);
   endproperty
   a_mps: assert property (p_mps) else $error("payload size not clamped");

   c_hot: cover property (@(posedge sys_clk) disable iff (!rst_s_n) hot_reset_pulse);
   c_msi: cover property (@(posedge sys_clk) disable iff (!rst_s_n) $rose(msi_en));
   c_err: cover property (@(posedge sys_clk) disable iff (!rst_s_n) pslverr);
endmodule // ipc_config_space

// ==== tb/ipc_side_model.sv ====
/*
 Side-band partner: slot power limit messages, PME requests, loader words.
 Assumes the bench calls send; signals change just after rising edges.
*/
`timescale 1ns/1ps
module ipc_side_model import ipc_pkg::*; (
   input  wire logic sys_clk,
   output logic       spl_valid,
   output logic [7:0] spl_value,
   output logic [1:0] spl_scale,
   output logic       pme_req,
   output logic       ld_valid,
   output logic [7:0] ld_addr,
   output ipc_word_t  ld_data
);
   initial begin
      {spl_valid, spl_value, spl_scale, pme_req, ld_valid, ld_addr, ld_data} = '0;
   end
   // Kind 0 power limit, 1 PME request, 2 loader word; one-cycle pulse
   task automatic send(input logic [1:0] k, input ipc_word_t v, input logic [7:0] a);
      @(posedge sys_clk);
      spl_valid <= (k == 2'h0);
      pme_req <= (k == 2'h1);
      ld_valid <= (k == 2'h2);
      spl_value <= v[7:0];
      spl_scale <= v[9:8];
      ld_addr <= a;
      ld_data <= v;
      @(posedge sys_clk);
      {spl_valid, pme_req, ld_valid} <= 3'h0;
      // Stale fields flip so a late sample cannot pass by luck
      spl_value <= ~v[7:0];
      spl_scale <= ~v[9:8];
      ld_addr <= ~a;
      ld_data <= ~v;
   endtask
endmodule // ipc_side_model

// ==== tb/tb.sv ====
/*
 Self-checking bench for the isolated port configuration space.
 Assumes an APB slave that may stretch access and the side model.
*/
`timescale 1ns/1ps
`include "ipc_regs.svh"
module tb import ipc_pkg::*; ();
   logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic        data_sel_wr_en = 0, err, pready, pslverr, spl_valid, pme_req, ld_valid;
   logic        downstream_reset_out_n, hot_reset_pulse, internal_reset_pulse, pme_msg;
   logic        msi_en, intx_allowed;
   logic [1:0]  bar2_type = 2'h0, spl_scale, power_state;
   logic [7:0]  paddr = 8'h00, spl_value, ld_addr;
   logic [3:0]  pstrb = 4'hF, err_report_en;
   logic [2:0]  msi_mme, max_payload;
   logic [63:0] msi_addr;
   logic [15:0] msi_data;
   ipc_word_t   pwdata = '0, prdata, q, ld_data;
   int          failures = 0, check_count = 0, hot_n = 0, int_n = 0, pme_n = 0, drop_n = 0;
   logic [7:0]  r_off [9] = '{8'h2C, 8'h34, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h68, 8'h6C, 8'h70};
   ipc_word_t   r_exp [9] = '{{`IPC_DEF_SUBSYSTEM_DEVICE_CODE, `IPC_DEF_SUBSYSTEM_VENDOR_CODE}, 32'h40, 32'h100, 32'hC8034801,
                              32'h8, 32'h806805, 32'h2A410, 32'h8FC1, 32'h0};
   logic [7:0]  w_off [11] = '{8'h20, 8'h24, 8'h2C, 8'h3C, 8'h48, 8'h4C, 8'h50, 8'h54,
                              8'h6C, 8'h70, 8'h60};
   ipc_word_t   w_exp [11] = '{32'hFFF00000, 32'h0, {`IPC_DEF_SUBSYSTEM_DEVICE_CODE, `IPC_DEF_SUBSYSTEM_VENDOR_CODE},
                              32'h1FF, 32'hF16805, 32'hFFFFFFFC, 32'hFFFFFFFF, 32'hFFFF,
                              32'h8FC1, 32'h2F, 32'h0};

   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      hot_n <= hot_n + int'(hot_reset_pulse === 1'b1);
      int_n <= int_n + int'(internal_reset_pulse === 1'b1);
      pme_n <= pme_n + int'(pme_msg === 1'b1);
      drop_n <= drop_n + int'(rst_n && downstream_reset_out_n !== 1'b1);
   end

   ipc_config_space dut_u (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .bar2_type, .data_sel_wr_en, .pme_req,
      .spl_valid, .spl_value, .spl_scale, .ld_valid, .ld_addr, .ld_data,
      .downstream_reset_out_n, .hot_reset_pulse, .internal_reset_pulse, .pme_msg,
      .msi_en, .intx_allowed, .msi_mme, .msi_addr, .msi_data, .err_report_en,
      .max_payload, .power_state);
   ipc_side_model side_u (.sys_clk, .spl_valid, .spl_value, .spl_scale, .pme_req,
      .ld_valid, .ld_addr, .ld_data);

   task automatic close_out();
      $display("Checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input ipc_word_t d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         close_out();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input ipc_word_t e);
      apb(1'b0, a, '0);
      chk($sformatf("reg %h", a), e, q);
   endtask

   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      foreach (r_off[i]) rd(r_off[i], r_exp[i]);
      apb(1'b1, 8'h1C, '1);
      rd(8'h1C, 32'h0);
      bar2_type <= 2'h2;
      apb(1'b1, 8'h1C, '1);
      rd(8'h1C, '1);
      foreach (w_off[i]) begin
         apb(1'b1, w_off[i], '1);
         rd(w_off[i], w_exp[i]);
         chk("slverr", w_off[i] == 8'h60, err);
      end
      chk("ctl", {msi_en, intx_allowed, msi_mme, err_report_en, max_payload}, 12'hBF9);
      chk("msi_addr", 64'hFFFFFFFF_FFFFFFFC, msi_addr);
      chk("msi_data", 16'hFFFF, msi_data);
      apb(1'b1, 8'h44, '1);
      rd(8'h44, 32'h10B);
      chk("state", 2'h3, power_state);
      data_sel_wr_en <= 1'b1;
      apb(1'b1, 8'h44, 32'h1E03);
      rd(8'h44, 32'h1E0B);
      // Leaving D3hot with the skip bit set: hot reset only
      apb(1'b1, 8'h44, 32'h0);
      rd(8'h44, 32'h8);
      chk("resets", {hot_n[7:0], int_n[7:0], drop_n[7:0]}, 24'h010000);
      apb(1'b1, 8'h44, 32'h100);
      side_u.send(2'h1, '0, 8'h00);
      apb(1'b1, 8'h44, 32'h0);
      side_u.send(2'h1, '0, 8'h00);
      rd(8'h44, 32'h8);
      chk("pme", 8'h01, pme_n[7:0]);
      side_u.send(2'h0, 32'h2A5, 8'h00);
      rd(8'h6C, 32'h0A948FC1);
      side_u.send(2'h2, 32'h50, 8'h34);
      rd(8'h34, 32'h50);
      // Loader clears the skip bit, so leaving D3hot also resets internally
      side_u.send(2'h2, 32'h0, 8'h44);
      apb(1'b1, 8'h44, 32'h3);
      apb(1'b1, 8'h44, 32'h0);
      rd(8'h3C, 32'h100);
      chk("resets2", {hot_n[7:0], int_n[7:0]}, 16'h0201);
      close_out();
   end
endmodule // tb
